// ---- pkg/gate_switch_pkg.sv ----
// shared types and constants for the gate switch logic
package gate_switch_pkg;

  // magnet holding-force test length at power-up, in us
  localparam int unsigned force_test_us     = 1000;
  localparam int unsigned clk_mhz           = 25;
  localparam int unsigned force_test_cycles = force_test_us * clk_mhz;
  localparam logic [15:0] force_test_last   =
    16'(force_test_cycles - 1);
  localparam logic [15:0] count_zero        = 16'h0000;
  localparam logic [15:0] count_step        = 16'h0001;

  typedef enum logic [1:0]
  {
    feas_normal  = 2'b00,
    feas_unequal = 2'b01,
    feas_locked  = 2'b10
  } feas_state_type;

  typedef struct packed
  {
    logic ch1;
    logic ch2;
  } safety_pair_type;

  typedef struct packed
  {
    logic winding_open;
    logic winding_short;
    logic force_ok;
  } magnet_sense_type;

endpackage

// ---- rtl/gate_switch.sv ----
// control logic of the coded gate switch with magnetic locking
//
// Contract
// - outputs high only with actuator, inputs, lock and force test good.
// - any failing condition drives both safety outputs low.
// - gate closed output follows actuator presence alone.
// - one input falling while the other stays high flags unequal inputs.
// - fallen input rising again: feasibility error, lock, outputs off.
// - normal operation resumes only after both inputs were low together.
// - after the force test the magnet is on only with lock command high and actuator present; during the test it is held on.
// - the holding force is tested at power-up and gates the outputs.
// - an open or shorted winding while energised after the force test forces both outputs low.
// - forced opening while locked drops both outputs.
// - any matching coded actuator is accepted on entry without teach-in.
// - a lock request that fails to lock shows a lock fault.
`timescale 1ns/1ns
module gate_switch
(
  input  wire logic                              sys_clk,
  input  wire logic                              rst_b,
  input  wire logic                              actuator_present,
  input  wire gate_switch_pkg::safety_pair_type  safety_in,
  input  wire logic                              lock_command_in,
  input  wire gate_switch_pkg::magnet_sense_type magnet_sense,
  output logic                                   safety_out_ch1,
  output logic                                   safety_out_ch2,
  output logic                                   gate_closed_out,
  output logic                                   magnet_on,
  output logic                                   unequal_out,
  output logic                                   feas_error_out,
  output logic                                   lock_fault_out,
  output logic                                   winding_fault_out
);

  logic        inputs_ok;
  logic        unequal;
  logic        feas_error;
  logic [15:0] test_cnt_q;
  logic [15:0] test_cnt_d;
  logic        test_done_q;
  logic        test_done_d;
  logic        force_ok_q;
  logic        force_ok_d;
  logic        wind_q;
  logic        wind_d;
  logic        out_q;
  logic        out_d;
  logic        magnet_q;
  logic        magnet_d;
  logic        gate_q;
  logic        gate_d;
  logic        unequal_q;
  logic        unequal_d;
  logic        feas_q;
  logic        feas_d;
  logic        lock_fault_q;
  logic        lock_fault_d;

  // chained use works since each input is just one upstream output
  input_feasibility u_feas
  (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .in_pair    (safety_in),
    .inputs_ok  (inputs_ok),
    .unequal    (unequal),
    .feas_error (feas_error)
  );

  // force test group
  always_comb
  begin
    test_cnt_d  = test_cnt_q;
    test_done_d = test_done_q;
    force_ok_d  = force_ok_q;
    // force test runs once after reset, magnet held on meanwhile
    if (!test_done_q)
    begin
      if (test_cnt_q == gate_switch_pkg::force_test_last)
      begin
        test_done_d = 1'b1;
        force_ok_d  = magnet_sense.force_ok;
      end
      else
      begin
        test_cnt_d = test_cnt_q + gate_switch_pkg::count_step;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      test_cnt_q  <= gate_switch_pkg::count_zero;
      test_done_q <= 1'b0;
      force_ok_q  <= 1'b0;
    end
    else
    begin
      test_cnt_q  <= test_cnt_d;
      test_done_q <= test_done_d;
      force_ok_q  <= force_ok_d;
    end
  end

  // magnet drive group
  always_comb
  begin
    magnet_d = 1'b1;
    if (test_done_q)
    begin
      magnet_d = lock_command_in && actuator_present;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      magnet_q <= 1'b0;
    end
    else
    begin
      magnet_q <= magnet_d;
    end
  end

  // winding fault latches until reset: supply cycle is the remedy
  always_comb
  begin
    wind_d = wind_q || (magnet_q && test_done_q &&
             (magnet_sense.winding_open ||
              magnet_sense.winding_short));
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      wind_q <= 1'b0;
    end
    else
    begin
      wind_q <= wind_d;
    end
  end

  // actuator leaving range drops outputs even while locked
  always_comb
  begin
    out_d = actuator_present && inputs_ok && lock_command_in &&
            test_done_q && force_ok_q && !wind_q &&
            !feas_error;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      out_q <= 1'b0;
    end
    else
    begin
      out_q <= out_d;
    end
  end

  // status flags, one cycle behind their sources
  always_comb
  begin
    gate_d    = actuator_present;
    unequal_d = unequal;
    feas_d    = feas_error;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      gate_q    <= 1'b0;
      unequal_q <= 1'b0;
      feas_q    <= 1'b0;
    end
    else
    begin
      gate_q    <= gate_d;
      unequal_q <= unequal_d;
      feas_q    <= feas_d;
    end
  end

  // request present but not locked; cleared by dropping the command
  always_comb
  begin
    lock_fault_d = lock_fault_q;
    if (!lock_command_in)
    begin
      lock_fault_d = 1'b0;
    end
    else if (test_done_q && (!actuator_present || !force_ok_q))
    begin
      lock_fault_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      lock_fault_q <= 1'b0;
    end
    else
    begin
      lock_fault_q <= lock_fault_d;
    end
  end

  assign safety_out_ch1    = out_q;
  assign safety_out_ch2    = out_q;
  assign gate_closed_out   = gate_q;
  assign magnet_on         = magnet_q;
  assign unequal_out       = unequal_q;
  assign feas_error_out    = feas_q;
  assign lock_fault_out    = lock_fault_q;
  assign winding_fault_out = wind_q;

endmodule // gate_switch

// ---- rtl/input_feasibility.sv ----
// discrepancy monitor for the two safety input channels
`timescale 1ns/1ns
module input_feasibility
(
  input  wire logic                            sys_clk,
  input  wire logic                            rst_b,
  input  wire gate_switch_pkg::safety_pair_type in_pair,
  output logic                                 inputs_ok,
  output logic                                 unequal,
  output logic                                 feas_error
);

  gate_switch_pkg::feas_state_type state_q;
  gate_switch_pkg::feas_state_type state_d;
  gate_switch_pkg::safety_pair_type prev_q;
  logic                             armed_q;
  logic                             armed_d;

  always_comb
  begin
    state_d = state_q;
    armed_d = armed_q;
    // both low together re-arms the channels
    if (!in_pair.ch1 && !in_pair.ch2)
    begin
      armed_d = 1'b1;
    end
    case (state_q)
      gate_switch_pkg::feas_normal:
      begin
        if ((prev_q.ch1 && !in_pair.ch1 && in_pair.ch2) ||
            (prev_q.ch2 && !in_pair.ch2 && in_pair.ch1))
        begin
          state_d = gate_switch_pkg::feas_unequal;
        end
      end
      gate_switch_pkg::feas_unequal:
      begin
        if (in_pair.ch1 && in_pair.ch2)
        begin
          state_d = gate_switch_pkg::feas_locked;
          armed_d = 1'b0;
        end
        else if (!in_pair.ch1 && !in_pair.ch2)
        begin
          state_d = gate_switch_pkg::feas_normal;
        end
      end
      gate_switch_pkg::feas_locked:
      begin
        if (!in_pair.ch1 && !in_pair.ch2)
        begin
          state_d = gate_switch_pkg::feas_normal;
        end
      end
      default:
      begin
        state_d = gate_switch_pkg::feas_locked;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      state_q <= gate_switch_pkg::feas_normal;
      prev_q  <= '0;
      armed_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      prev_q  <= in_pair;
      armed_q <= armed_d;
    end
  end

  // both channels must have been low together since reset before enabling
  assign inputs_ok  = (state_q == gate_switch_pkg::feas_normal) &&
                      armed_q && in_pair.ch1 && in_pair.ch2;
  assign unequal    = (state_q == gate_switch_pkg::feas_unequal);
  assign feas_error = (state_q == gate_switch_pkg::feas_locked);

endmodule // input_feasibility

// ---- verif/eval_model.sv ----
// evaluation device model: lock command and two-channel check
`timescale 1ns/1ns
module eval_model
#(
  parameter int low_min = 8
)
(
  input  logic sys_clk,
  input  logic rst_b,
  input  logic lock_req,
  input  logic out_ch1,
  input  logic out_ch2,
  output logic lock_cmd,
  output logic chan_ok,
  output logic chan_bad
);
  int low_q = 0;
  initial lock_cmd = 1'b0;
  // shortened low time, real one would stretch the run
  always @(posedge sys_clk)
  begin
    low_q <= (!rst_b || lock_cmd) ? 0 : low_q + 1;
    lock_cmd <= rst_b && lock_req && (lock_cmd || low_q >= low_min);
  end
  assign chan_ok  = out_ch1 && out_ch2;
  assign chan_bad = out_ch1 ^ out_ch2;
endmodule // eval_model

// ---- verif/gate_switch_props.sv ----
// assertions on the gate switch ports
`timescale 1ns/1ns
module gate_switch_props
(
  input logic                              sys_clk,
  input logic                              rst_b,
  input logic                              actuator_present,
  input gate_switch_pkg::safety_pair_type  safety_in,
  input logic                              lock_command_in,
  input gate_switch_pkg::magnet_sense_type magnet_sense,
  input logic                              safety_out_ch1,
  input logic                              safety_out_ch2,
  input logic                              gate_closed_out,
  input logic                              magnet_on,
  input logic                              unequal_out,
  input logic                              feas_error_out,
  input logic                              lock_fault_out,
  input logic                              winding_fault_out
);
  logic armed_q;
  logic all_ok;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // outputs high once means the force test is over
  always_ff @(posedge sys_clk)
    armed_q <= rst_b && (armed_q || safety_out_ch1);
  assign all_ok = actuator_present && safety_in == 2'h3 && lock_command_in;
  a_out_needs_all: assert property ($past(rst_b) && safety_out_ch1
    |-> $past(all_ok)) else $error("output high without cause");
  a_outs_paired: assert property (safety_out_ch1 == safety_out_ch2)
    else $error("outputs differ");
  a_drop_on_fail: assert property (!all_ok |=> !safety_out_ch1)
    else $error("output kept high");
  a_gate_follows: assert property ($past(rst_b) |->
    gate_closed_out == $past(actuator_present)) else $error("gate flag");
  a_magnet_cause: assert property (armed_q && magnet_on |->
    $past(lock_command_in && actuator_present)) else $error("magnet");
  a_unequal_flag: assert property (safety_out_ch1 && safety_in == 2'h1
    |-> ##[1:2] unequal_out) else $error("no unequal flag");
  a_feas_hold: assert property (feas_error_out |-> !safety_out_ch1)
    else $error("output high in lock");
  a_winding_off: assert property (armed_q && magnet_on
    && magnet_sense.winding_open |-> ##[1:2] !safety_out_ch1)
    else $error("winding fault ignored");
  a_lock_fault: assert property ((armed_q && lock_command_in
    && !actuator_present)[*2] |-> ##[0:2] lock_fault_out)
    else $error("no lock fault");
endmodule // gate_switch_props
bind gate_switch gate_switch_props u_props (.*);

// ---- verif/test_gate_switch.sv ----
// self-checking bench for the gate switch
`timescale 1ns/1ns
module test_gate_switch;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic act = 1'b0;
  logic req = 1'b0;
  gate_switch_pkg::safety_pair_type sin = 2'h0;
  gate_switch_pkg::magnet_sense_type ms = 3'h1;
  logic lock, o1, o2, gate, mag, uneq, ferr, lfault, wfault, c_ok, c_bad;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  gate_switch dut (.sys_clk(sys_clk), .rst_b(rst_b),
    .actuator_present(act), .safety_in(sin), .lock_command_in(lock),
    .magnet_sense(ms), .safety_out_ch1(o1), .safety_out_ch2(o2),
    .gate_closed_out(gate), .magnet_on(mag), .unequal_out(uneq),
    .feas_error_out(ferr), .lock_fault_out(lfault),
    .winding_fault_out(wfault));
  eval_model #(.low_min(8)) far (.sys_clk(sys_clk), .rst_b(rst_b),
    .lock_req(req), .out_ch1(o1), .out_ch2(o2), .lock_cmd(lock),
    .chan_ok(c_ok), .chan_bad(c_bad));
  initial
  begin
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic close_out();
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      errors = errors + 1;
      close_out();
    end
  end
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // checks 1 ns past the edge, once registered outputs have landed
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // inputs change on the edge itself, by non-blocking assignment
  task automatic align();
    @(posedge sys_clk);
  endtask
  task automatic s_enable();
    align();
    act <= 1'b1;
    tick(1);
    chk({gate, mag, o1, o2}, 4'h8);
    align();
    sin <= 2'h3;
    req <= 1'b1;
    tick(3);
    chk({gate, mag, o1, o2}, 4'hf);
    chk({c_ok, c_bad, lfault, uneq}, 4'h8);
  endtask
  task automatic s_fail();
    align();
    act <= 1'b0;
    tick(3);
    chk({o1 | o2, gate, mag, lfault}, 4'h1);
    align();
    req <= 1'b0;
    act <= 1'b1;
    tick(3);
    chk({o1, mag, lfault, gate}, 4'h1);
    align();
    req <= 1'b1;
    tick(3);
    chk({o1, mag, lock, gate}, 4'h1);
    tick(10);
    chk({o1, o2, mag, lock}, 4'hf);
  endtask
  task automatic s_feas();
    align();
    sin <= 2'h1;
    tick(3);
    chk({o1, uneq, ferr, o2}, 4'h4);
    align();
    sin <= 2'h3;
    tick(3);
    chk({o1, ferr, o2, 1'b0}, 4'h4);
    align();
    sin <= 2'h0;
    tick(2);
    align();
    sin <= 2'h3;
    tick(3);
    chk({o1, o2, ferr, uneq}, 4'hc);
  endtask
  task automatic s_wind();
    align();
    ms <= 3'h5;
    tick(3);
    chk({o1, o2, wfault, 1'b0}, 4'h2);
  endtask
  initial
  begin
    tick(8);
    align();
    rst_b <= 1'b1;
    tick(100);
    chk({mag, o1, o2, gate}, 4'h8);
    tick(24920);
    s_enable();
    s_fail();
    s_feas();
    s_wind();
    close_out();
  end
endmodule // test_gate_switch
